// ==== hdl/xram_address_mapper.sv ====
// external data ram address mapper with page select and flash write routing
// Operation
// - 512-byte ram in external data space
// - reachable by pointer and indirect moves
// - 8-bit operand takes high byte from page
// - moves go to ram by default
// - pointer access uses only low 9 bits
// - ram aliases every 512 bytes
// - write moves can route to flash
`default_nettype none
module xram_address_mapper #(
   parameter int RAM_BYTES = xram_pkg::XRAM_BYTES,
   parameter int RAM_AW    = xram_pkg::XRAM_AW
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        resetn,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // external data move from the core
   input  wire logic        mv_req,
   input  wire logic        mv_write,
   input  wire logic        mv_indirect,
   input  wire logic [15:0] mv_addr,
   input  wire logic [7:0]  mv_wdata,
   output logic      [7:0]  mv_rdata,
   // flash write path
   output logic             flash_wr,
   output logic      [15:0] flash_addr,
   output logic      [7:0]  flash_wdata
);
   // ************************************************************
   // registers
   // ************************************************************
   logic              page_choice_bit_q, page_choice_bit_d;
   logic              flash_we_q, flash_we_d;
   logic [15:0]       last_addr_q, last_addr_d;
   logic [7:0]        reg_rdata_q, reg_rdata_d;
   logic              flash_wr_q, flash_wr_d;
   logic [15:0]       flash_addr_q, flash_addr_d;
   logic [7:0]        flash_wdata_q, flash_wdata_d;
   logic [15:0]       full_addr;
   logic [RAM_AW-1:0] ram_addr;
   logic              ram_we;
   logic              ram_re;

   // indirect moves carry only a byte; page bit supplies the high byte
   function automatic logic [15:0] form_addr(input logic ind, input logic [15:0] a, input logic pg);
      form_addr = ind ? {7'h00, pg, a[xram_pkg::PAGE_AW-1:0]} : a;
   endfunction

   // register strobe aimed at one offset
   function automatic logic reg_hit(input logic stb, input logic [7:0] a, input logic [7:0] off);
      reg_hit = stb && (a == off);
   endfunction

   always_comb begin
      full_addr = form_addr(mv_indirect, mv_addr, page_choice_bit_q);
      ram_addr  = full_addr[RAM_AW-1:0];
      // flash only when software enabled it; otherwise ram by default
      ram_we    = mv_req & mv_write & ~flash_we_q;
      ram_re    = mv_req & ~mv_write;
   end

   // ************************************************************
   // page select register
   // ************************************************************
   always_comb begin
      page_choice_bit_d = page_choice_bit_q;
      if (reg_hit(reg_wr, reg_addr, xram_pkg::PAGE_SEL_OFFSET)) begin
         page_choice_bit_d = reg_wdata[xram_pkg::PAGE_BIT_POS];
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         page_choice_bit_q <= xram_pkg::PAGE_SEL_RESET[xram_pkg::PAGE_BIT_POS];
      end else begin
         page_choice_bit_q <= page_choice_bit_d;
      end
   end

   // ************************************************************
   // flash write enable
   // ************************************************************
   always_comb begin
      flash_we_d = flash_we_q;
      if (reg_hit(reg_wr, reg_addr, xram_pkg::FLASH_CTL_OFFSET)) begin
         flash_we_d = reg_wdata[xram_pkg::FLASH_WE_POS];
      end
   end

   // cleared at reset so every move reaches the ram until software opts in
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         flash_we_q <= xram_pkg::FLASH_CTL_RESET[xram_pkg::FLASH_WE_POS];
      end else begin
         flash_we_q <= flash_we_d;
      end
   end

   // ************************************************************
   // last move address
   // ************************************************************
   always_comb begin
      last_addr_d = last_addr_q;
      if (mv_req) begin
         last_addr_d = full_addr;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         last_addr_q <= 16'h0000;
      end else begin
         last_addr_q <= last_addr_d;
      end
   end

   // ************************************************************
   // register read data
   // ************************************************************
   // data stand one cycle only; idle zero keeps the port quiet between reads
   always_comb begin
      reg_rdata_d = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            xram_pkg::PAGE_SEL_OFFSET:  reg_rdata_d = {7'h00, page_choice_bit_q};
            xram_pkg::FLASH_CTL_OFFSET: reg_rdata_d = {7'h00, flash_we_q};
            xram_pkg::ADDR_HI_OFFSET:   reg_rdata_d = last_addr_q[15:8];
            xram_pkg::ADDR_LO_OFFSET:   reg_rdata_d = last_addr_q[7:0];
            default:                    reg_rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata_q <= 8'h00;
      end else begin
         reg_rdata_q <= reg_rdata_d;
      end
   end

   // ************************************************************
   // flash write outputs
   // ************************************************************
   // address and data hold after the pulse so a slow flash engine can take them late
   always_comb begin
      flash_wr_d    = 1'b0;
      flash_addr_d  = flash_addr_q;
      flash_wdata_d = flash_wdata_q;
      if (mv_req && mv_write && flash_we_q) begin
         flash_wr_d    = 1'b1;
         flash_addr_d  = full_addr;
         flash_wdata_d = mv_wdata;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         flash_wr_q    <= 1'b0;
         flash_addr_q  <= 16'h0000;
         flash_wdata_q <= 8'h00;
      end else begin
         flash_wr_q    <= flash_wr_d;
         flash_addr_q  <= flash_addr_d;
         flash_wdata_q <= flash_wdata_d;
      end
   end

   // ************************************************************
   // ram
   // ************************************************************
   xram_mem #(
      .AW    (RAM_AW),
      .DEPTH (RAM_BYTES)
   ) u_mem (
      .mclk  (mclk),
      .addr  (ram_addr),
      .we    (ram_we),
      .wdata (mv_wdata),
      .re    (ram_re),
      .rdata (mv_rdata)
   );

   assign reg_rdata   = reg_rdata_q;
   assign flash_wr    = flash_wr_q;
   assign flash_addr  = flash_addr_q;
   assign flash_wdata = flash_wdata_q;
endmodule
`default_nettype wire

// ==== hdl/xram_pkg.sv ====
// package: register map, field layout and sizes of the external ram mapper
`default_nettype none
package xram_pkg;
   localparam int          XRAM_BYTES       = 512;
   localparam int          XRAM_AW          = 9;
   localparam int          PAGE_AW          = 8;
   localparam logic [7:0]  PAGE_SEL_OFFSET  = 8'haa;
   localparam logic [7:0]  PAGE_SEL_RESET   = 8'h00;
   localparam int          PAGE_BIT_POS     = 0;
   localparam logic [7:0]  FLASH_CTL_OFFSET = 8'h8f;
   localparam logic [7:0]  FLASH_CTL_RESET  = 8'h00;
   localparam int          FLASH_WE_POS     = 0;
   localparam logic [7:0]  ADDR_HI_OFFSET   = 8'hb0;
   localparam logic [7:0]  ADDR_LO_OFFSET   = 8'hb1;
endpackage
`default_nettype wire

// ==== hdl/xram_mem.sv ====
// single-port byte ram with registered read data
`default_nettype none
module xram_mem #(
   parameter int AW = 9,
   parameter int DEPTH = 512
) (
   // clock
   input  wire logic          mclk,
   // access
   input  wire logic [AW-1:0] addr,
   input  wire logic          we,
   input  wire logic [7:0]    wdata,
   input  wire logic          re,
   output logic      [7:0]    rdata
);
   logic [7:0] mem [DEPTH];

   // no reset: ram contents are undefined at power-up
   always_ff @(posedge mclk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      if (re) begin
         rdata <= mem[addr];
      end
   end
endmodule
`default_nettype wire

// ==== tb/xam_properties.sv ====
// checker: port timing of the external ram mapper
`default_nettype none
module xam_checker (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        resetn,
   // register port
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic [7:0]  reg_rdata,
   // move port
   input  wire logic        mv_req,
   input  wire logic        mv_write,
   input  wire logic        mv_indirect,
   input  wire logic [15:0] mv_addr,
   input  wire logic [7:0]  mv_wdata,
   // flash path
   input  wire logic        flash_wr,
   input  wire logic [15:0] flash_addr,
   input  wire logic [7:0]  flash_wdata
);
   timeunit 1ns; timeprecision 100ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   logic fen_q; // shadow of the flash write enable
   always_ff @(posedge mclk or negedge resetn)
      if (!resetn) fen_q <= 1'b0;
      else if (reg_wr && reg_addr == 8'h8f) fen_q <= reg_wdata[0];
   property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_pg_hi; $past(reg_rd && reg_addr == 8'haa) |-> reg_rdata[7:1] == 7'h00; endproperty
   a_pg_hi: assert property (p_pg_hi) else $error("page upper bits set");
   property p_pg_rw; reg_wr && reg_addr == 8'haa ##1 !reg_wr ##1 reg_rd && reg_addr == 8'haa
      |=> reg_rdata == ($past(reg_wdata, 3) & 8'h01); endproperty
   a_pg_rw: assert property (p_pg_rw) else $error("page readback wrong");
   property p_fl_src; flash_wr |-> $past(mv_req && mv_write && fen_q); endproperty
   a_fl_src: assert property (p_fl_src) else $error("stray flash write");
   property p_fl_go; mv_req && mv_write && fen_q |=> flash_wr; endproperty
   a_fl_go: assert property (p_fl_go) else $error("flash write missing");
   // indirect moves take the high byte from the page bit, so only the low byte is known here
   property p_fl_dat; flash_wr |-> flash_wdata == $past(mv_wdata) &&
      ($past(mv_indirect) ? flash_addr[7:0] == $past(mv_addr[7:0]) : flash_addr == $past(mv_addr)); endproperty
   a_fl_dat: assert property (p_fl_dat) else $error("flash address or data wrong");
   property p_ram_dflt; mv_req && !(mv_write && fen_q) |=> !flash_wr; endproperty
   a_ram_dflt: assert property (p_ram_dflt) else $error("move left the ram");
   property p_fl_hold; !flash_wr |-> $stable(flash_addr) && $stable(flash_wdata); endproperty
   a_fl_hold: assert property (p_fl_hold) else $error("flash outputs moved");
endmodule
bind xram_address_mapper xam_checker u_chk (.mclk, .resetn, .reg_wr, .reg_rd, .mv_req, .mv_write, .mv_indirect,
   .flash_wr, .reg_addr, .reg_wdata, .reg_rdata, .mv_wdata, .flash_wdata, .mv_addr, .flash_addr);
`default_nettype wire

// ==== tb/xam_core.sv ====
// core model: issues external data moves
`default_nettype none
module xam_core (
   // clock
   input  wire logic        mclk,
   // read data from the mapper
   input  wire logic [7:0]  mv_rdata,
   // move request
   output logic             mv_req,
   output logic             mv_write,
   output logic             mv_indirect,
   output logic      [15:0] mv_addr,
   output logic      [7:0]  mv_wdata
);
   timeunit 1ns; timeprecision 100ps;
   initial {mv_req, mv_write, mv_indirect, mv_addr, mv_wdata} = '0;
   // idle address and data lines show the inverse so stale values cannot pass; write and indirect keep their values
   task automatic mv(input logic w, i, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge mclk); {mv_req, mv_write, mv_indirect, mv_addr, mv_wdata} <= {1'b1, w, i, a, d};
      @(posedge mclk); {mv_req, mv_addr, mv_wdata} <= {1'b0, ~a, ~d};
      @(negedge mclk); q = mv_rdata;
   endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// testbench: register and move sequences for the external ram mapper
`default_nettype none
module testbench;
   timeunit 1ns; timeprecision 100ps;
   logic mclk = 0, resetn = 1, reg_wr = 0, reg_rd = 0, mv_req, mv_write, mv_indirect, flash_wr;
   logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, mv_wdata, mv_rdata, flash_wdata, q;
   logic [15:0] mv_addr, flash_addr;
   int fail_count = 0, compares = 0, cyc = 0, pulses = 0;
   xram_address_mapper DUT (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mv_req,
      .mv_write, .mv_indirect, .mv_addr, .mv_wdata, .mv_rdata, .flash_wr, .flash_addr, .flash_wdata);
   xam_core core (.mclk, .mv_rdata, .mv_req, .mv_write, .mv_indirect, .mv_addr, .mv_wdata);
   initial forever #12.5 mclk = ~mclk;
   task automatic complete_run;
      if (fail_count == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (flash_wr === 1'b1) pulses <= pulses + 1;
      if (cyc == 2000) begin
         fail_count++;
         complete_run;
      end
   end
   task automatic chk(input logic [15:0] got, exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge mclk); {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge mclk); reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge mclk); {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge mclk); reg_rd <= 1'b0;
      @(negedge mclk); v = reg_rdata;
   endtask
   initial begin
      resetn <= 1'b0;
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      rd(8'haa, q); chk(q, 8'h00);
      rd(8'h8f, q); chk(q, 8'h00);
      wr(8'haa, 8'hff); rd(8'haa, q); chk(q, 8'h01);
      core.mv(1'b1, 1'b1, 16'hff34, 8'h3c, q);
      rd(8'hb0, q); chk(q, 8'h01);
      rd(8'hb1, q); chk(q, 8'h34);
      core.mv(1'b0, 1'b0, 16'h0334, 8'h00, q); chk(q, 8'h3c);
      wr(8'haa, 8'h00);
      core.mv(1'b1, 1'b0, 16'hfe05, 8'ha5, q);
      core.mv(1'b0, 1'b1, 16'h0005, 8'h00, q); chk(q, 8'ha5);
      core.mv(1'b0, 1'b0, 16'h0205, 8'h00, q); chk(q, 8'ha5);
      wr(8'h8f, 8'h01); core.mv(1'b1, 1'b0, 16'h1205, 8'h9e, q);
      chk(flash_addr, 16'h1205);
      chk(flash_wdata, 8'h9e);
      core.mv(1'b1, 1'b1, 16'hff77, 8'h11, q); chk(flash_addr, 16'h0077);
      wr(8'h8f, 8'h00); chk(16'(pulses), 16'h0002);
      core.mv(1'b0, 1'b0, 16'hfa05, 8'h00, q); chk(q, 8'ha5);
      complete_run;
   end
endmodule
`default_nettype wire
